//--- core/srfs_supervisor.sv
// supply rail fault supervisor: deglitch, blanking, fault flags, oscillator and checksum checks
//
// Local design decisions: the address map and the APB interface to the registers.
`default_nettype none
module srfs_supervisor #(
	parameter int unsigned DGL_CYC        = srfs_pkg::DGL_CYC,
	parameter int unsigned BLANK_CYC      = srfs_pkg::BLANK_CYC,
	parameter int unsigned NVM_PERIOD_CYC = srfs_pkg::NVM_PERIOD_CYC,
	parameter int unsigned BIST_CELL_VOLTAGE_WINDOW_CYC  = srfs_pkg::BIST_CELL_VOLTAGE_WINDOW_CYC,
	parameter int unsigned BIST_CELL_TEMP_WINDOW_CYC  = srfs_pkg::BIST_CELL_TEMP_WINDOW_CYC,
	parameter int unsigned CELL_VOLTAGE_WINDOW_STEPS     = srfs_pkg::CELL_VOLTAGE_WINDOW_STEPS,
	parameter int unsigned CELL_TEMP_WINDOW_STEPS     = srfs_pkg::CELL_TEMP_WINDOW_STEPS
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire srfs_pkg::srfs_cmp_t         cmp,
	input  wire logic                        core_below_reset,
	input  wire logic                        lfo_clk,
	input  wire logic                        frame_valid,
	input  wire logic [63:0]                 frame_data,
	input  wire logic [7:0]                  frame_crc,
	output logic                             frame_done,
	output logic                             frame_ok,
	output logic [srfs_pkg::NVM_AW-1:0]      nvm_addr,
	input  wire logic [15:0]                 nvm_data,
	input  wire logic [7:0]                  nvm_ref_crc,
	output logic                             power_down,
	output logic                             digital_reset,
	output logic                             bias_ref_enable,
	output logic                             ctw_suspend,
	output logic                             bal_pin_filt,
	output logic                             sense_low_filt,
	output logic [3:0]                       cell_voltage_window_sel,
	output logic [2:0]                       cell_temp_window_sel,
	output logic                             bist_active
);
	localparam int CRC_MAX = srfs_pkg::FRAME_CRC_CYC;

	srfs_pkg::srfs_state_t s_q, s_d;
	srfs_pkg::srfs_cmp_t   gate, dglv;
	srfs_pkg::srfs_flt_a_t set_a, clr_a;
	srfs_pkg::srfs_flt_b_t set_b, clr_b;
	srfs_pkg::srfs_flt_c_t set_c, clr_c;
	logic [srfs_pkg::NCH-1:0] act;
	logic [31:0]              rd_mux;
	logic                     setup, wr, hit;
	logic                     sel_ctrl, sel_a, sel_b, sel_c, sel_stat;
	logic                     bias_en, st_en, blanking, cell_voltage_window_done, cell_temp_window_done;
	logic                     lfo_tick, lfo_bad, nvm_fail;
	logic [7:0]               nvm_next;

	// bitwise crc over the low nbytes of data, lsb first
	function automatic logic [7:0] crc8_fold(input logic [7:0] init, input logic [63:0] data,
			input int unsigned nbytes);
		logic [7:0] c;
		logic       fb;
		c = init;
		for (int i = 0; i < 64; i++) begin
			fb = c[7] ^ data[i];
			if (i < 8 * nbytes) begin
				c = {c[6:0], 1'b0} ^ (fb ? srfs_pkg::CRC_POLY : 8'h00);
			end
		end
		return c;
	endfunction : crc8_fold

	always_comb begin
		s_d = s_q;

		// register bus decode; zero wait states so pready is constant
		setup    = psel && !penable;
		wr       = psel && penable && pwrite;
		sel_ctrl = paddr[7:2] == srfs_pkg::REG_CONTROL_B[7:2];
		sel_a    = paddr[7:2] == srfs_pkg::REG_SUPPLY[7:2];
		sel_b    = paddr[7:2] == srfs_pkg::REG_SYS_B[7:2];
		sel_c    = paddr[7:2] == srfs_pkg::REG_SYS_C[7:2];
		sel_stat = paddr[7:2] == srfs_pkg::REG_STATUS[7:2];
		hit      = sel_ctrl || sel_a || sel_b || sel_c || sel_stat;

		bias_en   = s_q.ctrl[srfs_pkg::CTRL_BIAS_EN];
		st_en     = s_q.ctrl[srfs_pkg::CTRL_ST_EN];
		blanking  = !bias_en || (s_q.blank_cnt != srfs_pkg::TMR_W'(BLANK_CYC));
		cell_voltage_window_done = s_q.bist_cnt >= srfs_pkg::TMR_W'(BIST_CELL_VOLTAGE_WINDOW_CYC);
		cell_temp_window_done = s_q.bist_cnt >= srfs_pkg::TMR_W'(BIST_CELL_TEMP_WINDOW_CYC);

		if (wr && sel_ctrl) begin
			s_d.ctrl = pwdata[1:0];
		end

		// bias reference blanking restarts on every enable
		if (!bias_en) begin
			s_d.blank_cnt = '0;
		end else if (blanking) begin
			s_d.blank_cnt = s_q.blank_cnt + 1'b1;
		end

		// channels masked here never start their deglitch count
		gate        = '1;
		gate.bias_ov = !blanking;
		gate.bias_uv = !blanking;
		gate.ctw_st  = st_en && !blanking && !cell_temp_window_done;
		gate.cvw_st  = st_en && !cell_voltage_window_done;
		gate.bdc_st  = st_en && !cell_voltage_window_done;
		act = gate & cmp;

		// every channel must hold steadily for the full deglitch time
		for (int i = 0; i < srfs_pkg::NCH; i++) begin
			if (!act[i]) begin
				s_d.dcnt[i] = '0;
			end else if (s_q.dcnt[i] != srfs_pkg::DGL_W'(DGL_CYC)) begin
				s_d.dcnt[i] = s_q.dcnt[i] + 1'b1;
			end
			dglv[i] = s_d.dcnt[i] == srfs_pkg::DGL_W'(DGL_CYC);
		end
		s_d.dgl = dglv;

		// power down is terminal until the next power-on reset
		s_d.pwr_dn = s_q.pwr_dn || s_q.dgl.core_por || s_q.dgl.tshut || s_q.dgl.aon_uv;
		s_d.drst   = s_q.dgl.arail_uv || core_below_reset;

		// slow oscillator period check in core clock cycles
		s_d.lfo_q = lfo_clk;
		lfo_tick  = lfo_clk && !s_q.lfo_q;
		lfo_bad   = 1'b0;
		if (lfo_tick) begin
			s_d.lfo_cnt  = '0;
			s_d.lfo_seen = 1'b1;
			lfo_bad = s_q.lfo_seen && ((s_q.lfo_cnt + 1'b1) < srfs_pkg::LFO_W'(srfs_pkg::LFO_MIN_CYC));
			lfo_bad = lfo_bad || (s_q.lfo_seen && s_q.lfo_cnt >= srfs_pkg::LFO_W'(srfs_pkg::LFO_MAX_CYC));
		end else if (s_q.lfo_cnt != srfs_pkg::LFO_W'(srfs_pkg::LFO_MAX_CYC)) begin
			s_d.lfo_cnt = s_q.lfo_cnt + 1'b1;
		end else begin
			lfo_bad = 1'b1;
		end

		// self-test round-robins advance on slow oscillator edges
		if (!cell_voltage_window_done) begin
			s_d.bist_cnt = s_q.bist_cnt + 1'b1;
		end
		if (lfo_tick && st_en && !cell_voltage_window_done) begin
			s_d.cell_voltage_window_idx = (s_q.cell_voltage_window_idx == 4'(CELL_VOLTAGE_WINDOW_STEPS - 1)) ? 4'h0 : s_q.cell_voltage_window_idx + 1'b1;
		end
		if (lfo_tick && st_en && !cell_temp_window_done) begin
			s_d.cell_temp_window_idx = (s_q.cell_temp_window_idx == 3'(CELL_TEMP_WINDOW_STEPS - 1)) ? 3'h0 : s_q.cell_temp_window_idx + 1'b1;
		end

		// single-cycle frame check, far inside its time budget
		s_d.frame_done = frame_valid;
		s_d.frame_ok   = crc8_fold(8'h00, frame_data, 8) == frame_crc;

		// periodic memory checksum walk, one word per cycle
		nvm_fail = 1'b0;
		nvm_next = crc8_fold(s_q.nvm_crc, {48'h0, nvm_data}, 2);
		if (s_q.nvm_busy) begin
			s_d.nvm_crc  = nvm_next;
			s_d.nvm_addr = s_q.nvm_addr + 1'b1;
			if (s_q.nvm_addr == '1) begin
				s_d.nvm_busy = 1'b0;
				nvm_fail     = nvm_next != nvm_ref_crc;
			end
		end
		if (s_q.nvm_tmr == srfs_pkg::TMR_W'(NVM_PERIOD_CYC - 1)) begin
			s_d.nvm_tmr  = '0;
			s_d.nvm_busy = 1'b1;
			s_d.nvm_addr = '0;
			s_d.nvm_crc  = 8'h00;
		end else begin
			s_d.nvm_tmr = s_q.nvm_tmr + 1'b1;
		end

		set_a.arail_ov     = s_q.dgl.arail_ov;
		set_a.arail_uv_rst = s_q.dgl.arail_uv;
		set_a.xrail_ov     = s_q.dgl.xrail_ov;
		set_a.core_ov      = s_q.dgl.core_ov;
		set_a.bias_ov      = s_q.dgl.bias_ov;
		set_a.bias_uv      = s_q.dgl.bias_uv;
		set_b.xgnd_open     = s_q.dgl.xgnd_open;
		set_b.cgnd_open     = s_q.dgl.cgnd_open;
		set_b.arail_osc     = s_q.dgl.arail_osc;
		set_b.bias_osc      = s_q.dgl.bias_osc;
		set_b.mref_osc      = s_q.dgl.mref_osc;
		set_b.nvm_crc_err   = nvm_fail;
		set_b.frame_crc_err = s_q.frame_done && !s_q.frame_ok;
		set_c.slow_osc    = lfo_bad;
		set_c.aref_uv     = s_q.dgl.aref_uv;
		set_c.aon_ov      = s_q.dgl.aon_ov;
		set_c.aon_uv      = s_q.dgl.aon_uv;
		set_c.aon_sw      = s_q.dgl.aon_sw;
		set_c.tshut       = s_q.dgl.tshut;
		set_c.cvw_st_fail = s_q.dgl.cvw_st;
		set_c.ctw_st_fail = s_q.dgl.ctw_st;
		set_c.bdc_st_fail = s_q.dgl.bdc_st;

		// write one to clear; a new event in the same cycle wins
		clr_a = (wr && sel_a) ? pwdata[$bits(clr_a)-1:0] : '0;
		clr_b = (wr && sel_b) ? pwdata[$bits(clr_b)-1:0] : '0;
		clr_c = (wr && sel_c) ? pwdata[$bits(clr_c)-1:0] : '0;
		s_d.flt_a = (s_q.flt_a & ~clr_a) | set_a;
		s_d.flt_b = (s_q.flt_b & ~clr_b) | set_b;
		s_d.flt_c = (s_q.flt_c & ~clr_c) | set_c;

		unique case (1'b1)
			sel_ctrl: rd_mux = {30'h0, s_q.ctrl};
			sel_a:    rd_mux = {26'h0, s_q.flt_a};
			sel_b:    rd_mux = {25'h0, s_q.flt_b};
			sel_c:    rd_mux = {23'h0, s_q.flt_c};
			sel_stat: rd_mux = {5'h0, s_q.drst, s_q.pwr_dn, cell_temp_window_done, cell_voltage_window_done, blanking, s_q.dgl};
			default:  rd_mux = 32'h0;
		endcase
		// read data captured in setup so it is stable through the access phase
		if (setup) begin
			s_d.prdata = pwrite ? 32'h0 : rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata          = s_q.prdata;
	assign pready          = 1'b1;
	assign pslverr         = psel && penable && !hit;
	assign frame_done      = s_q.frame_done;
	assign frame_ok        = s_q.frame_ok;
	assign nvm_addr        = s_q.nvm_addr;
	assign power_down      = s_q.pwr_dn;
	assign digital_reset   = s_q.drst;
	assign bias_ref_enable = s_q.ctrl[srfs_pkg::CTRL_BIAS_EN];
	assign ctw_suspend     = blanking;
	assign bal_pin_filt    = s_q.dgl.bal_pin;
	assign sense_low_filt  = s_q.dgl.sense_low;
	assign cell_voltage_window_sel        = s_q.cell_voltage_window_idx;
	assign cell_temp_window_sel        = s_q.cell_temp_window_idx;
	assign bist_active     = st_en && !cell_voltage_window_done;

	// run length of the gated bias overvoltage input, for checking only
	logic [srfs_pkg::TMR_W-1:0] bias_run_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bias_run_q <= '0;
		end else begin
			bias_run_q <= act[16] ? bias_run_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_por_power_down: assert property (s_q.dgl.core_por |=> power_down)
		else $error("core power-on deglitch did not power down");
	chk_blank_bias_ignored: assert property ($past(blanking) && blanking |-> !s_q.dgl.bias_ov && !s_q.dgl.bias_uv)
		else $error("bias comparator acted during blanking");
	chk_bias_dgl_length: assert property ($rose(s_q.dgl.bias_ov) |-> bias_run_q >= srfs_pkg::TMR_W'(DGL_CYC))
		else $error("bias overvoltage qualified too early");
	chk_selftest_gated: assert property (!st_en ##1 !st_en |-> !s_q.dgl.cvw_st && !s_q.dgl.ctw_st)
		else $error("self-test result qualified while disabled");
	chk_aref_flag: assert property (s_q.dgl.aref_uv |=> s_q.flt_c.aref_uv)
		else $error("reference undervoltage not flagged");
	chk_aon_uv_down: assert property ($rose(s_q.dgl.aon_uv) |=> power_down ##1 power_down)
		else $error("always-on undervoltage did not power down");
	chk_bal_pin_drop: assert property (!cmp.bal_pin |=> !bal_pin_filt)
		else $error("balance comparator filter held after input low");
	chk_tshut_down: assert property (s_q.dgl.tshut |=> power_down && s_q.flt_c.tshut)
		else $error("thermal shutdown not taken");
	chk_ground_flag: assert property ($rose(s_q.flt_b.cgnd_open) |-> $past(s_q.dgl.cgnd_open))
		else $error("ground open flag without qualified cause");
	chk_frame_time: assert property (frame_valid |-> ##[1:CRC_MAX] frame_done)
		else $error("frame checksum result late");
	chk_nvm_period: assert property (s_q.nvm_tmr < srfs_pkg::TMR_W'(NVM_PERIOD_CYC))
		else $error("memory checksum period overrun");
	chk_arail_reset: assert property (s_q.dgl.arail_uv |=> digital_reset ##1 s_q.flt_a.arail_uv_rst)
		else $error("analog undervoltage reset path broken");
	chk_flag_sticky: assert property (s_q.flt_a.arail_ov && !(wr && sel_a && pwdata[0]) |=> s_q.flt_a.arail_ov)
		else $error("supply flag dropped without clear");
	chk_pd_held: assert property (power_down |=> power_down)
		else $error("power down released without reset");

	// flag, digital reset and sense-low filter paths: one cycle from cause to result
	chk_arail_ov_flag: assert property (s_q.dgl.arail_ov |=> s_q.flt_a.arail_ov)
		else $error("analog rail overvoltage not flagged");
	chk_xrail_ov_flag: assert property (s_q.dgl.xrail_ov |=> s_q.flt_a.xrail_ov)
		else $error("transceiver rail overvoltage not flagged");
	chk_core_ov_flag: assert property (s_q.dgl.core_ov |=> s_q.flt_a.core_ov)
		else $error("core rail overvoltage not flagged");
	chk_core_reset_hold: assert property (core_below_reset |=> digital_reset)
		else $error("core below reset threshold without digital reset");
	chk_bias_uv_flag: assert property (s_q.dgl.bias_uv |=> s_q.flt_a.bias_uv)
		else $error("bias undervoltage not flagged");
	chk_arail_osc_flag: assert property (s_q.dgl.arail_osc |=> s_q.flt_b.arail_osc)
		else $error("analog rail oscillation not flagged");
	chk_bias_osc_flag: assert property (s_q.dgl.bias_osc |=> s_q.flt_b.bias_osc)
		else $error("bias oscillation not flagged");
	chk_mref_osc_flag: assert property (s_q.dgl.mref_osc |=> s_q.flt_b.mref_osc)
		else $error("main reference oscillation not flagged");
	chk_xgnd_flag: assert property (s_q.dgl.xgnd_open |=> s_q.flt_b.xgnd_open)
		else $error("transceiver ground open not flagged");
	chk_aon_ov_flag: assert property (s_q.dgl.aon_ov |=> s_q.flt_c.aon_ov)
		else $error("always-on overvoltage not flagged");
	chk_aon_sw_flag: assert property (s_q.dgl.aon_sw |=> s_q.flt_c.aon_sw)
		else $error("always-on switch fault not flagged");
	chk_sense_low_drop: assert property (!cmp.sense_low |=> !sense_low_filt)
		else $error("sense-low filter held after input low");
	chk_frame_err_flag: assert property (frame_done && !frame_ok |=> s_q.flt_b.frame_crc_err)
		else $error("bad frame checksum not flagged");

	// self-test windows, slow oscillator and memory checksum walk
	chk_ctw_blanked: assert property (blanking |=> !s_q.dgl.ctw_st)
		else $error("temperature window acted during blanking");
	chk_cvw_window_end: assert property (cell_voltage_window_done |=> !s_q.dgl.cvw_st && !s_q.dgl.bdc_st)
		else $error("voltage window self-test ran past its time");
	chk_cell_voltage_window_step: assert property (lfo_tick && st_en && !cell_voltage_window_done |=> cell_voltage_window_sel != $past(cell_voltage_window_sel))
		else $error("voltage window round-robin did not step");
	chk_cell_voltage_window_hold: assert property (cell_voltage_window_done |=> cell_voltage_window_sel == $past(cell_voltage_window_sel))
		else $error("voltage window round-robin stepped after its time");
	chk_cell_temp_window_hold: assert property (cell_temp_window_done |=> cell_temp_window_sel == $past(cell_temp_window_sel))
		else $error("temperature round-robin stepped after its time");
	chk_cvw_flag: assert property (s_q.dgl.cvw_st |=> s_q.flt_c.cvw_st_fail)
		else $error("voltage window self-test fail not flagged");
	chk_ctw_flag: assert property (s_q.dgl.ctw_st |=> s_q.flt_c.ctw_st_fail)
		else $error("temperature window self-test fail not flagged");
	chk_bdc_flag: assert property (s_q.dgl.bdc_st |=> s_q.flt_c.bdc_st_fail)
		else $error("balance-done self-test fail not flagged");
	chk_lfo_timeout: assert property (!lfo_tick && s_q.lfo_cnt == srfs_pkg::LFO_W'(srfs_pkg::LFO_MAX_CYC) |=> s_q.flt_c.slow_osc)
		else $error("stopped slow oscillator not flagged");
	chk_lfo_short: assert property (lfo_tick && s_q.lfo_seen && s_q.lfo_cnt < srfs_pkg::LFO_W'(srfs_pkg::LFO_MIN_CYC - 1) |=> s_q.flt_c.slow_osc)
		else $error("fast slow oscillator not flagged");
	chk_nvm_walk_len: assert property ($rose(s_q.nvm_busy) |-> ##16 !s_q.nvm_busy)
		else $error("memory checksum walk length wrong");
endmodule : srfs_supervisor
`default_nettype wire

//--- core/srfs_pkg.sv
// constants, carriers and state record for the supply rail fault supervisor
`default_nettype none
package srfs_pkg;
	localparam int unsigned CLK_HZ         = 250_000_000;
	localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int unsigned DGL_US         = 25;
	localparam int unsigned DGL_CYC        = DGL_US * CLK_MHZ;
	localparam int unsigned BLANK_MS       = 2;
	localparam int unsigned BLANK_CYC      = BLANK_MS * 1000 * CLK_MHZ;
	localparam int unsigned FRAME_CRC_US   = 2;
	localparam int unsigned FRAME_CRC_CYC  = FRAME_CRC_US * CLK_MHZ;
	localparam int unsigned NVM_PERIOD_MS  = 2;
	localparam int unsigned NVM_PERIOD_CYC = NVM_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int unsigned BIST_CELL_VOLTAGE_WINDOW_US   = 4500;
	localparam int unsigned BIST_CELL_VOLTAGE_WINDOW_CYC  = BIST_CELL_VOLTAGE_WINDOW_US * CLK_MHZ;
	localparam int unsigned BIST_CELL_TEMP_WINDOW_US   = 2400;
	localparam int unsigned BIST_CELL_TEMP_WINDOW_CYC  = BIST_CELL_TEMP_WINDOW_US * CLK_MHZ;
	localparam int unsigned LFO_FMIN_HZ    = 196_500;
	localparam int unsigned LFO_FMAX_HZ    = 327_500;
	// shortest legal period rounds up, longest rounds down
	localparam int unsigned LFO_MIN_CYC    = (CLK_HZ + LFO_FMAX_HZ - 1) / LFO_FMAX_HZ;
	localparam int unsigned LFO_MAX_CYC    = CLK_HZ / LFO_FMIN_HZ;
	localparam int unsigned CELL_VOLTAGE_WINDOW_STEPS     = 12;
	localparam int unsigned CELL_TEMP_WINDOW_STEPS     = 6;
	localparam logic [7:0]  CRC_POLY       = 8'h07;

	localparam int unsigned TMR_W  = 24;
	localparam int unsigned DGL_W  = 16;
	localparam int unsigned LFO_W  = 12;
	localparam int unsigned NVM_AW = 4;
	localparam int unsigned NCH    = 22;

	localparam logic [7:0] REG_CONTROL_B = 8'h00;
	localparam logic [7:0] REG_SUPPLY    = 8'h04;
	localparam logic [7:0] REG_SYS_B     = 8'h08;
	localparam logic [7:0] REG_SYS_C     = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam int unsigned CTRL_BIAS_EN = 0;
	localparam int unsigned CTRL_ST_EN   = 1;

	typedef struct packed {
		logic arail_ov, arail_uv, xrail_ov, core_ov, core_por, bias_ov, bias_uv, aref_uv;
		logic aon_ov, aon_uv, aon_sw, tshut, xgnd_open, cgnd_open, arail_osc, bias_osc;
		logic mref_osc, bal_pin, sense_low, cvw_st, ctw_st, bdc_st;
	} srfs_cmp_t;

	typedef struct packed {
		logic bias_uv, bias_ov, core_ov, xrail_ov, arail_uv_rst, arail_ov;
	} srfs_flt_a_t;

	typedef struct packed {
		logic frame_crc_err, nvm_crc_err, mref_osc, bias_osc, arail_osc, cgnd_open, xgnd_open;
	} srfs_flt_b_t;

	typedef struct packed {
		logic bdc_st_fail, ctw_st_fail, cvw_st_fail, tshut, aon_sw, aon_uv, aon_ov, aref_uv, slow_osc;
	} srfs_flt_c_t;

	typedef struct packed {
		logic [NCH-1:0][DGL_W-1:0] dcnt;
		srfs_cmp_t                 dgl;
		logic [1:0]                ctrl;
		srfs_flt_a_t               flt_a;
		srfs_flt_b_t               flt_b;
		srfs_flt_c_t               flt_c;
		logic [31:0]               prdata;
		logic [TMR_W-1:0]          blank_cnt;
		logic                      lfo_q;
		logic                      lfo_seen;
		logic [LFO_W-1:0]          lfo_cnt;
		logic [TMR_W-1:0]          bist_cnt;
		logic [3:0]                cell_voltage_window_idx;
		logic [2:0]                cell_temp_window_idx;
		logic                      pwr_dn;
		logic                      drst;
		logic                      frame_done;
		logic                      frame_ok;
		logic [TMR_W-1:0]          nvm_tmr;
		logic                      nvm_busy;
		logic [NVM_AW-1:0]         nvm_addr;
		logic [7:0]                nvm_crc;
	} srfs_state_t;
endpackage : srfs_pkg
`default_nettype wire

//--- verif/srfs_tb.sv
// self-checking bench for the supply rail fault supervisor
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned DG = 8;
	logic        pclk, presetn, psel, penable, pwrite, core_below_reset, lfo_clk, frame_valid;
	logic [7:0]  paddr, frame_crc, nvm_ref_crc;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, err, frame_done, frame_ok, power_down, digital_reset;
	logic        bias_ref_enable, ctw_suspend, bal_pin_filt, sense_low_filt, bist_active;
	logic [21:0] cmp_v;
	logic [63:0] frame_data;
	logic [3:0]  nvm_addr, cell_voltage_window_sel;
	logic [2:0]  cell_temp_window_sel;
	logic [15:0] mem [16];
	int          fails, n_checks, cycles;

	srfs_supervisor #(.DGL_CYC(DG), .BLANK_CYC(40), .NVM_PERIOD_CYC(64), .BIST_CELL_VOLTAGE_WINDOW_CYC(200),
		.BIST_CELL_TEMP_WINDOW_CYC(100)) srfs_supervisor_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmp(srfs_pkg::srfs_cmp_t'(cmp_v)), .core_below_reset(core_below_reset), .lfo_clk(lfo_clk),
		.frame_valid(frame_valid), .frame_data(frame_data), .frame_crc(frame_crc),
		.frame_done(frame_done), .frame_ok(frame_ok), .nvm_addr(nvm_addr), .nvm_data(mem[nvm_addr]),
		.nvm_ref_crc(nvm_ref_crc), .power_down(power_down), .digital_reset(digital_reset),
		.bias_ref_enable(bias_ref_enable), .ctw_suspend(ctw_suspend), .bal_pin_filt(bal_pin_filt),
		.sense_low_filt(sense_low_filt), .cell_voltage_window_sel(cell_voltage_window_sel), .cell_temp_window_sel(cell_temp_window_sel),
		.bist_active(bist_active));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			give_verdict();
		end
	end

	// lsb-first serial crc, poly 0x07, chained through c
	function automatic logic [7:0] crc8(input logic [63:0] d, input int n, input logic [7:0] c);
		for (int i = 0; i < n; i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8

	function automatic logic [7:0] nvm_crc();
		logic [7:0] c;
		c = 8'h00;
		for (int w = 0; w < 16; w++)
			c = crc8({48'h0, mem[w]}, 16, c);
		return c;
	endfunction : nvm_crc

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: register %h expected %h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: signal %b expected %b", $time, got, exp);
		end
	endtask : chk1

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50)
			fails++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// slow oscillator flag ignored here: lfo stands still in most scenarios
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk32(rd & ((a == 8'h0C) ? 32'hFFFFFFFE : 32'hFFFFFFFF), exp);
	endtask : rdchk

	task automatic hold(input int b, input int n);
		cmp_v[b] <= 1'b1;
		repeat (n) @(posedge pclk);
		cmp_v[b] <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : hold

	task automatic low_freq_oscillator(input int n, input int p);
		repeat (n) begin
			lfo_clk <= 1'b1;
			repeat (p / 2) @(posedge pclk);
			lfo_clk <= 1'b0;
			repeat (p / 2) @(posedge pclk);
		end
	endtask : low_freq_oscillator

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset

	task automatic t_regs();
		for (int i = 0; i < 4; i++) rdchk(8'(i * 4), 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk1(err, 1'b1);
		chk32(rd, 32'h0);
		apb(1'b1, 8'h00, 32'h3);
		rdchk(8'h00, 32'h3);
		apb(1'b1, 8'h00, 32'h0);
	endtask : t_regs

	task automatic t_dgl();
		int bi [12] = '{21, 20, 19, 18, 14, 13, 11, 9, 8, 7, 6, 5};
		logic [7:0] ad [12] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h0C, 8'h0C, 8'h0C, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08};
		int fb [12] = '{0, 1, 2, 3, 1, 2, 4, 0, 1, 2, 3, 4};
		for (int i = 0; i < 12; i++) begin
			hold(bi[i], DG - 1);
			rdchk(ad[i], 32'h0);
			hold(bi[i], DG + 2);
			rdchk(ad[i], 32'h1 << fb[i]);
			repeat (20) @(posedge pclk);
			rdchk(ad[i], 32'h1 << fb[i]);
			apb(1'b1, ad[i], 32'h1 << fb[i]);
			rdchk(ad[i], 32'h0);
		end
	endtask : t_dgl

	task automatic t_drst();
		cmp_v[20] <= 1'b1;
		repeat (DG + 3) @(posedge pclk);
		#1 chk1(digital_reset, 1'b1);
		cmp_v[20] <= 1'b0;
		core_below_reset <= 1'b1;
		repeat (3) @(posedge pclk);
		#1 chk1(digital_reset, 1'b1);
		core_below_reset <= 1'b0;
		repeat (3) @(posedge pclk);
		#1 chk1(digital_reset, 1'b0);
	endtask : t_drst

	task automatic t_filt();
		for (int b = 3; b < 5; b++) begin
			cmp_v[b] <= 1'b1;
			repeat (DG - 1) @(posedge pclk);
			#1 chk1(b == 4 ? bal_pin_filt : sense_low_filt, 1'b0);
			repeat (4) @(posedge pclk);
			#1 chk1(b == 4 ? bal_pin_filt : sense_low_filt, 1'b1);
			cmp_v[b] <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask : t_filt

	task automatic t_bias();
		do_reset();
		apb(1'b1, 8'h00, 32'h1);
		#1 chk1(bias_ref_enable, 1'b1);
		chk1(ctw_suspend, 1'b1);
		hold(16, 20);
		rdchk(8'h04, 32'h0);
		repeat (40) @(posedge pclk);
		#1 chk1(ctw_suspend, 1'b0);
		hold(15, DG + 2);
		rdchk(8'h04, 32'h20);
	endtask : t_bias

	task automatic send(input logic [63:0] d, input logic [7:0] c, input logic ok);
		frame_data <= d;
		frame_crc <= c;
		frame_valid <= 1'b1;
		@(posedge pclk);
		frame_valid <= 1'b0;
		#1 chk1(frame_done, 1'b1);
		chk1(frame_ok, ok);
		@(posedge pclk);
	endtask : send

	task automatic t_frame();
		do_reset();
		send(64'h0123456789ABCDEF, crc8(64'h0123456789ABCDEF, 64, 8'h00), 1'b1);
		send(64'hFEDCBA9876543210, ~crc8(64'hFEDCBA9876543210, 64, 8'h00), 1'b0);
		repeat (3) @(posedge pclk);
		rdchk(8'h08, 32'h40);
	endtask : t_frame

	task automatic t_nvm();
		do_reset();
		repeat (200) @(posedge pclk);
		rdchk(8'h08, 32'h0);
		nvm_ref_crc <= ~nvm_crc();
		repeat (200) @(posedge pclk);
		rdchk(8'h08, 32'h20);
		nvm_ref_crc <= nvm_crc();
	endtask : t_nvm

	task automatic t_lfo();
		do_reset();
		low_freq_oscillator(4, 1000);
		apb(1'b0, 8'h0C, 32'h0);
		chk1(rd[0], 1'b0);
		low_freq_oscillator(4, 500);
		apb(1'b0, 8'h0C, 32'h0);
		chk1(rd[0], 1'b1);
	endtask : t_lfo

	task automatic t_bist();
		logic [3:0] ov;
		logic [2:0] ot;
		do_reset();
		apb(1'b1, 8'h00, 32'h2);
		#1 chk1(bist_active, 1'b1);
		ov = cell_voltage_window_sel;
		ot = cell_temp_window_sel;
		low_freq_oscillator(1, 20);
		#1 chk1(cell_voltage_window_sel === ((ov == 4'hB) ? 4'h0 : ov + 4'h1), 1'b1);
		chk1(cell_temp_window_sel === ((ot == 3'h5) ? 3'h0 : ot + 3'h1), 1'b1);
		hold(2, DG + 2);
		rdchk(8'h0C, 32'h40);
		repeat (200) @(posedge pclk);
		#1 chk1(bist_active, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk1(rd[23], 1'b1);
		chk1(rd[24], 1'b1);
	endtask : t_bist

	task automatic t_pd();
		int bi [3] = '{17, 10, 12};
		logic [31:0] fl [3] = '{32'h0, 32'h20, 32'h8};
		for (int i = 0; i < 3; i++) begin
			do_reset();
			hold(bi[i], DG - 1);
			#1 chk1(power_down, 1'b0);
			hold(bi[i], DG + 2);
			#1 chk1(power_down, 1'b1);
			repeat (20) @(posedge pclk);
			#1 chk1(power_down, 1'b1);
			rdchk(8'h0C, fl[i]);
		end
	endtask : t_pd

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	initial begin
		{presetn, psel, penable, pwrite, core_below_reset, lfo_clk, frame_valid} = 7'h00;
		{paddr, frame_crc, pwdata, cmp_v, frame_data} = '0;
		fails = 0;
		n_checks = 0;
		cycles = 0;
		for (int w = 0; w < 16; w++)
			mem[w] = 16'hA5C3 ^ (16'(w) * 16'h1111);
		nvm_ref_crc = nvm_crc();
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_dgl();
		t_drst();
		t_filt();
		t_bias();
		t_frame();
		t_nvm();
		t_lfo();
		t_bist();
		t_pd();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
